// [design/ccr_command_handler.sv]
`timescale 1ns/1ps
// ============================================================
// Overview of operation
// - Processor-card activation needs antenna power; returns select answer or fail code.
// - Key load takes slot 0 to 4 plus twelve hex characters, stored nonvolatile.
// - Stored keys can never be read back; keys are write only.
// - Card-type query answers one digit, or fail code on no card or power.
// - Deselect sends the layer-4 deselect frame; acknowledge or fail code.
// - APDU exchange carries at most 262 bytes; returns data and status words.
// - Raw exchange CRC character 30h means CRC included, 31h means none.
// - Raw exchange has a four-digit wait time and at most 384 data bytes.
// - Codes: 5Eh done, 2Ah not completed, 3Fh reception error.
// - Codes: 21h bad command, 7Eh no hardware, 2Bh no stripe, 3Ah power on.
// - Automatic mode reads sensed cards alone and sends data only on success.
// - Automatic-mode disable stops reading until the arm-to-read command arrives.
// - Disable changes only the volatile mode; enable restores automatic reading.
// - Persistent configuration writes the automatic-mode setting to nonvolatile storage.
// - After arming, a card read gives acknowledge whether or not decoding worked.
// - Antenna power-on is refused with fail code while automatic mode is on.
module ccr_command_handler
    import ccr_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = GAP_CYC
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxBad,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic cardSense,
    input wire logic stripeSwipe,
    input wire logic cardHwReady,
    output logic antennaOn,
    output logic autoMode,
    output logic cardGo,
    output ccr_card_op_t cardOp,
    output logic [13:0] cardWaitMs,
    output logic cardCrcOn,
    output logic cardFlush,
    output logic cardTxValid,
    output logic [7:0] cardTxData,
    input wire logic cardDone,
    input wire logic cardOk,
    input wire logic cardRxValid,
    input wire logic [7:0] cardRxData,
    input wire logic cardRxLast,
    output logic cardRxReady,
    input wire logic nvAutoMode,
    output logic nvKeyWr,
    output logic [2:0] nvKeySlot,
    output logic [47:0] nvKeyData,
    output logic nvModeWr,
    output logic nvModeAuto
);
    typedef enum logic [2:0] {S_POWERON, S_IDLE, S_ARGS, S_DISPATCH, S_ARM, S_CARD, S_STREAM, S_DRAIN} ccr_state_t;

    // ============================================================
    // Decoding helpers
    function automatic logic isDigit(input logic [7:0] c);
        return (c >= CH_0) && (c <= CH_9);
    endfunction

    function automatic logic isHex(input logic [7:0] c);
        return isDigit(c) || ((c >= CH_A) && (c <= CH_F));
    endfunction

    function automatic logic [3:0] hexVal(input logic [7:0] c);
        return isDigit(c) ? c[3:0] : 4'(c[3:0] + 4'h9);
    endfunction

    // ============================================================
    // Reset release and pin synchronisers
    logic [1:0] rstSync_q;
    logic [1:0] senseSync_q;
    logic [1:0] stripeSync_q;
    logic senseLast_q;
    logic stripeLast_q;
    wire logic rstn = rstSync_q[1];

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end

    // Sensor pins pass two flops before the edge detectors
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            senseSync_q <= 2'h0;
            stripeSync_q <= 2'h0;
            senseLast_q <= 1'b0;
            stripeLast_q <= 1'b0;
        end
        else
        begin
            senseSync_q <= {senseSync_q[0], cardSense};
            stripeSync_q <= {stripeSync_q[0], stripeSwipe};
            senseLast_q <= senseSync_q[1];
            stripeLast_q <= stripeSync_q[1];
        end
    end

    wire logic senseRise = senseSync_q[1] && !senseLast_q;
    wire logic stripeRise = stripeSync_q[1] && !stripeLast_q;

    // ============================================================
    // Command collection
    ccr_state_t state_q;
    logic [7:0] cmd_q;
    logic [7:0] arg0_q;
    logic [7:0] arg1_q;
    logic [9:0] cnt_q;
    logic [13:0] num_q;
    logic [47:0] key_q;
    logic argBad_q;
    logic commErr_q;
    logic [GAP_W-1:0] gapCnt_q;
    logic antennaOn_q;
    logic autoMode_q;
    ccr_resp_if rsp ();

    wire logic newCmd = (state_q == S_IDLE) && rxValid;
    wire logic rxTake = (state_q == S_ARGS) && rxValid;
    wire logic gapDone = (state_q == S_ARGS) && !rxValid && (gapCnt_q == GAP_W'(GAP_CYCLES - 1));
    wire logic isV = cmd_q == CMD_SECTOR_WR;
    wire logic isZ = cmd_q == CMD_APDU;
    wire logic isRaw = cmd_q == CMD_RAW;
    wire logic isKey = cmd_q == CMD_KEY_LOAD;
    wire logic bForm = (cnt_q == 10'h000) ? (rxData == CH_B) : (arg0_q == CH_B);
    wire logic decPos = (isV && !bForm && cnt_q < SECTOR_HDR) || (isRaw && cnt_q >= 10'h001 && cnt_q < RAW_HDR);
    wire logic keyPos = isKey && cnt_q >= 10'h001 && cnt_q < KEY_LEN;
    wire logic [13:0] numNext = decPos ? 14'(num_q * DEC_BASE + {10'h000, rxData[3:0]})
        : (isV && bForm && cnt_q == 10'h002) ? {6'h00, rxData} : num_q;
    wire logic badNow = (decPos && !isDigit(rxData))
        || (isV && bForm && cnt_q == 10'h001 && rxData != BYTE_ZERO)
        || (isKey && cnt_q == 10'h000 && (rxData < CH_0 || rxData > CH_4))
        || (keyPos && !isHex(rxData))
        || (isRaw && cnt_q == 10'h000 && rxData != CH_0 && rxData != CH_1);
    wire logic isPayload = (isV && cnt_q >= SECTOR_HDR) || isZ || (isRaw && cnt_q >= RAW_HDR);

    // Gather arguments; the command closes after an idle gap
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_q <= BYTE_ZERO;
            arg0_q <= BYTE_ZERO;
            arg1_q <= BYTE_ZERO;
            cnt_q <= 10'h000;
            num_q <= 14'h0000;
            key_q <= 48'h0;
            argBad_q <= 1'b0;
            commErr_q <= 1'b0;
        end
        else if (newCmd)
        begin
            cmd_q <= rxData;
            cnt_q <= 10'h000;
            num_q <= 14'h0000;
            argBad_q <= 1'b0;
            commErr_q <= rxBad;
        end
        else if (rxTake)
        begin
            cnt_q <= (cnt_q == CNT_MAX) ? cnt_q : 10'(cnt_q + 10'h001);
            commErr_q <= commErr_q || rxBad;
            argBad_q <= argBad_q || badNow;
            num_q <= numNext;
            arg0_q <= (cnt_q == 10'h000) ? rxData : arg0_q;
            arg1_q <= (cnt_q == 10'h001) ? rxData : arg1_q;
            key_q <= keyPos ? {key_q[43:0], hexVal(rxData)} : key_q;
        end
    end

    // Idle gap counter, restarted by every host byte
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            gapCnt_q <= '0;
        else if (newCmd || rxTake || state_q != S_ARGS)
            gapCnt_q <= '0;
        else
            gapCnt_q <= GAP_W'(gapCnt_q + 1'b1);
    end

    // Payload bytes stream straight to the card engine
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cardTxValid <= 1'b0;
            cardTxData <= BYTE_ZERO;
        end
        else
        begin
            cardTxValid <= rxTake && isPayload;
            cardTxData <= rxData;
        end
    end

    // ============================================================
    // Dispatch decision
    wire logic [9:0] secLen = (num_q >= LARGE_FIRST && num_q <= LARGE_LAST) ? SECTOR_LARGE : SECTOR_SMALL;
    wire logic noArgCmd = cmd_q == CMD_ACTIVATE || cmd_q == CMD_IDENTIFY || cmd_q == CMD_DESELECT
        || cmd_q == CMD_ANT_ON || cmd_q == CMD_ANT_OFF || cmd_q == CMD_ARM;
    wire logic binArg1 = arg1_q == CH_0 || arg1_q == CH_1;
    wire logic paramOk = isV ? (!argBad_q && num_q <= SECTOR_MAXNUM && cnt_q == 10'(SECTOR_HDR + secLen))
        : noArgCmd ? cnt_q == 10'h000
        : isKey ? (!argBad_q && cnt_q == KEY_LEN)
        : isZ ? (cnt_q >= APDU_MIN && cnt_q <= APDU_MAX)
        : isRaw ? (!argBad_q && cnt_q >= RAW_HDR && cnt_q <= 10'(RAW_HDR + RAW_MAX))
        : (cmd_q == CMD_AUTO) ? (cnt_q == 10'h001 && (arg0_q == CH_0 || arg0_q == CH_1))
        : (cmd_q == CMD_PERSIST) ? (cnt_q == 10'h002 && arg0_q == PERSIST_SEL && binArg1)
        : 1'b0;
    wire logic needCard = isV || isZ || isRaw || cmd_q == CMD_ACTIVATE
        || cmd_q == CMD_IDENTIFY || cmd_q == CMD_DESELECT;
    wire logic needAnt = needCard || isKey;
    wire logic autoBlocked = autoMode_q && (cmd_q == CMD_ANT_ON || cmd_q == CMD_ANT_OFF || cmd_q == CMD_ARM);
    wire logic [7:0] dispCode = commErr_q ? RSP_COMM
        : !paramOk ? RSP_BAD
        : (needCard && !cardHwReady) ? RSP_UNAVAIL
        : (needAnt && !antennaOn_q) ? RSP_FAIL
        : autoBlocked ? RSP_FAIL
        : RSP_ACK;
    wire logic dispAck = (state_q == S_DISPATCH) && dispCode == RSP_ACK;
    wire logic goCard = dispAck && needCard;
    wire logic goArm = dispAck && cmd_q == CMD_ARM;
    wire ccr_card_op_t dispOp = isV ? CARD_SECTOR_WR : isZ ? CARD_APDU : isRaw ? CARD_RAW
        : (cmd_q == CMD_ACTIVATE) ? CARD_ACTIVATE : (cmd_q == CMD_IDENTIFY) ? CARD_IDENTIFY : CARD_DESELECT;

    // ============================================================
    // Card results and response selection
    logic autoRun_q;
    logic armRun_q;
    wire logic armTrig = (state_q == S_ARM) && (senseRise || stripeRise);
    wire logic autoTrig = (state_q == S_IDLE) && !rxValid && autoMode_q && (senseRise || stripeRise);
    wire logic cardEnd = (state_q == S_CARD) && cardDone;
    wire logic hasData = cardOp == CARD_ACTIVATE || cardOp == CARD_IDENTIFY || cardOp == CARD_APDU
        || cardOp == CARD_RAW || cardOp == CARD_READ;
    wire logic toStream = cardEnd && cardOk && hasData && !armRun_q;
    wire logic silentEnd = cardEnd && autoRun_q && !cardOk;
    wire logic cardStatus = cardEnd && !toStream && !silentEnd;
    wire logic [7:0] cardCode = (armRun_q || cardOk) ? RSP_ACK : RSP_FAIL;
    wire logic streamBeat = (state_q == S_STREAM) && cardRxValid && rsp.streamReady;

    // One response per command, taken by the emitter
    assign rsp.statusValid = (state_q == S_POWERON) || ((state_q == S_DISPATCH) && !goCard && !goArm)
        || cardStatus;
    assign rsp.statusCode = (state_q == S_POWERON) ? RSP_POWER : cardEnd ? cardCode : dispCode;
    assign rsp.streamValid = (state_q == S_STREAM) && cardRxValid;
    assign rsp.streamData = cardRxData;
    assign cardRxReady = (state_q == S_STREAM) && rsp.streamReady;
    assign antennaOn = antennaOn_q;
    assign autoMode = autoMode_q;

    // Sequencer: one command in flight until its answer has gone out
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= S_POWERON;
        else
        begin
            unique case (state_q)
                S_POWERON: state_q <= S_DRAIN;
                S_IDLE: state_q <= newCmd ? S_ARGS : autoTrig ? S_CARD : S_IDLE;
                S_ARGS: state_q <= gapDone ? S_DISPATCH : S_ARGS;
                S_DISPATCH: state_q <= goCard ? S_CARD : goArm ? S_ARM : S_DRAIN;
                S_ARM: state_q <= armTrig ? S_CARD : S_ARM;
                S_CARD: state_q <= toStream ? S_STREAM : silentEnd ? S_IDLE : cardEnd ? S_DRAIN : S_CARD;
                S_STREAM: state_q <= (streamBeat && cardRxLast) ? S_DRAIN : S_STREAM;
                S_DRAIN: state_q <= rsp.idle ? S_IDLE : S_DRAIN;
            endcase
        end
    end

    // Card engine launch and operation arguments
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cardGo <= 1'b0;
            cardOp <= CARD_READ;
            cardWaitMs <= 14'h0000;
            cardCrcOn <= 1'b0;
            cardFlush <= 1'b0;
            autoRun_q <= 1'b0;
            armRun_q <= 1'b0;
        end
        else
        begin
            cardGo <= goCard || armTrig || autoTrig;
            cardFlush <= (state_q == S_DISPATCH) && needCard && !goCard; // Drop streamed payload
            if (goCard)
            begin
                cardOp <= dispOp;
                cardWaitMs <= num_q;
                cardCrcOn <= arg0_q == CH_0;
                autoRun_q <= 1'b0;
                armRun_q <= 1'b0;
            end
            else if (armTrig || autoTrig)
            begin
                cardOp <= CARD_READ;
                autoRun_q <= autoTrig;
                armRun_q <= armTrig;
            end
        end
    end

    // Volatile mode, antenna and the power-up load of the stored mode
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            antennaOn_q <= 1'b0;
            autoMode_q <= 1'b1;
        end
        else if (state_q == S_POWERON)
            autoMode_q <= nvAutoMode;
        else if (dispAck && cmd_q == CMD_AUTO)
            autoMode_q <= arg0_q == CH_1;
        else if (dispAck && (cmd_q == CMD_ANT_ON || cmd_q == CMD_ANT_OFF))
            antennaOn_q <= cmd_q == CMD_ANT_ON;
    end

    // Nonvolatile writes; keys leave only towards storage, never to the host
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nvKeyWr <= 1'b0;
            nvKeySlot <= 3'h0;
            nvKeyData <= 48'h0;
            nvModeWr <= 1'b0;
            nvModeAuto <= 1'b0;
        end
        else
        begin
            nvKeyWr <= dispAck && isKey;
            nvKeySlot <= arg0_q[2:0];
            nvKeyData <= key_q;
            nvModeWr <= dispAck && cmd_q == CMD_PERSIST;
            nvModeAuto <= arg1_q == CH_1;
        end
    end

    // ============================================================
    // Host byte emitter
    ccr_tx_emitter emitter (
        .clk(ref_clk),
        .rstn(rstn),
        .rsp(rsp),
        .txData(txData),
        .txValid(txValid),
        .txReady(txReady)
    );
endmodule

// [design/ccr_pkg.sv]
// ============================================================
// Shared constants and types of the card command handler
package ccr_pkg;
    // Response codes sent to the host
    localparam logic [7:0] RSP_ACK = 8'h5e;
    localparam logic [7:0] RSP_FAIL = 8'h2a;
    localparam logic [7:0] RSP_NOSTRIPE = 8'h2b;
    localparam logic [7:0] RSP_COMM = 8'h3f;
    localparam logic [7:0] RSP_BAD = 8'h21;
    localparam logic [7:0] RSP_POWER = 8'h3a;
    localparam logic [7:0] RSP_UNAVAIL = 8'h7e;

    // Host command letters
    localparam logic [7:0] CMD_SECTOR_WR = 8'h76;
    localparam logic [7:0] CMD_ACTIVATE = 8'h4a;
    localparam logic [7:0] CMD_KEY_LOAD = 8'h6a;
    localparam logic [7:0] CMD_IDENTIFY = 8'h46;
    localparam logic [7:0] CMD_DESELECT = 8'h79;
    localparam logic [7:0] CMD_APDU = 8'h5a;
    localparam logic [7:0] CMD_RAW = 8'h7a;
    localparam logic [7:0] CMD_ANT_ON = 8'h4f;
    localparam logic [7:0] CMD_ANT_OFF = 8'h6f;
    localparam logic [7:0] CMD_AUTO = 8'h48;
    localparam logic [7:0] CMD_ARM = 8'h50;
    localparam logic [7:0] CMD_PERSIST = 8'h53;
    localparam logic [7:0] PERSIST_SEL = 8'h41;

    // ASCII characters used in argument checks
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_4 = 8'h34;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_B = 8'h42;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Argument byte counts (after the command letter)
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [9:0] SECTOR_HDR = 10'h003;
    localparam logic [9:0] SECTOR_SMALL = 10'h040;
    localparam logic [9:0] SECTOR_LARGE = 10'h100;
    localparam logic [13:0] SECTOR_MAXNUM = 14'h00ff;
    localparam logic [13:0] LARGE_FIRST = 14'h0020;
    localparam logic [13:0] LARGE_LAST = 14'h0027;
    localparam logic [9:0] KEY_LEN = 10'h00d;
    localparam logic [9:0] APDU_MIN = 10'h005;
    localparam logic [9:0] APDU_MAX = 10'h106;
    localparam logic [9:0] RAW_HDR = 10'h005;
    localparam logic [9:0] RAW_MAX = 10'h180;
    localparam logic [13:0] DEC_BASE = 14'h000a;

    // Inter-byte gap that closes a host command
    localparam int CLK_MHZ = 200;
    localparam int GAP_US = 1000;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int GAP_W = 18;

    // Operations handed to the card engine
    typedef enum logic [2:0] {
        CARD_SECTOR_WR,
        CARD_ACTIVATE,
        CARD_IDENTIFY,
        CARD_DESELECT,
        CARD_APDU,
        CARD_RAW,
        CARD_READ
    } ccr_card_op_t;
endpackage

// [design/ccr_resp_if.sv]
`timescale 1ns/1ps
// ============================================================
// Response path between command handler and byte emitter
interface ccr_resp_if;
    logic statusValid;
    logic [7:0] statusCode;
    logic streamValid;
    logic [7:0] streamData;
    logic streamReady;
    logic idle;
    modport src (output statusValid, statusCode, streamValid, streamData, input streamReady, idle);
    modport snk (input statusValid, statusCode, streamValid, streamData, output streamReady, idle);
endinterface

// [design/ccr_tx_emitter.sv]
`timescale 1ns/1ps
// ============================================================
// One-byte holding stage towards the host transmitter
module ccr_tx_emitter
    import ccr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    ccr_resp_if.snk rsp,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady
);
    logic [7:0] txData_q;
    logic txValid_q;
    wire logic take = (rsp.statusValid || rsp.streamValid) && rsp.streamReady;

    // Free when empty or when the held byte leaves this cycle
    assign rsp.streamReady = !txValid_q || txReady;
    assign rsp.idle = !txValid_q;
    assign txData = txData_q;
    assign txValid = txValid_q;

    // Load a status code or a card data byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            txData_q <= BYTE_ZERO;
            txValid_q <= 1'b0;
        end
        else if (take)
        begin
            txData_q <= rsp.statusValid ? rsp.statusCode : rsp.streamData;
            txValid_q <= 1'b1;
        end
        else if (txReady)
        begin
            txValid_q <= 1'b0;
        end
    end
endmodule

// [dv/ccr_cmd_assertions.sv]
`timescale 1ns/1ps
// ============================================================
// Port checks of the card command handler
module ccr_cmd_assertions
    import ccr_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = GAP_CYC
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic antennaOn,
    input wire logic autoMode,
    input wire logic cardGo,
    input wire ccr_card_op_t cardOp,
    input wire logic [13:0] cardWaitMs,
    input wire logic cardDone,
    input wire logic cardOk,
    input wire logic nvKeyWr,
    input wire logic [2:0] nvKeySlot,
    input wire logic nvModeWr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Acknowledge byte offered to the host
    sequence ackOut;
        txValid && txData == RSP_ACK;
    endsequence

    a_tx_holds: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx byte changed before accept");
    a_key_ack: assert property (nvKeyWr |-> nvKeySlot <= 3'h4 ##[0:3] ackOut)
        else $error("key store without valid slot or ack");
    a_mode_ack: assert property (nvModeWr |-> ##[0:3] ackOut)
        else $error("mode store without ack");
    a_card_antenna: assert property (cardGo && cardOp != CARD_READ |-> antennaOn)
        else $error("card command without antenna");
    a_antenna_manual: assert property ($rose(antennaOn) |-> !autoMode)
        else $error("antenna on in automatic mode");
    a_raw_wait: assert property (cardGo && cardOp == CARD_RAW |-> cardWaitMs <= 14'h270f)
        else $error("raw wait out of range");
    a_auto_silent: assert property (cardDone && !cardOk && autoMode && cardOp == CARD_READ |=> (!txValid) [*4])
        else $error("failed auto read sent data");
    a_armed_ack: assert property (cardDone && !autoMode && cardOp == CARD_READ |-> ##[1:3] ackOut)
        else $error("armed read without ack");
    a_desel_fail: assert property (cardDone && !cardOk && cardOp == CARD_DESELECT |-> ##[1:3] txValid && txData == RSP_FAIL)
        else $error("failed deselect without fail code");
endmodule

bind ccr_command_handler ccr_cmd_assertions #(.GAP_CYCLES(GAP_CYCLES)) u_chk (.*);

// [dv/ccr_card_model.sv]
`timescale 1ns/1ps
// ============================================================
// Card engine standing behind the handler
module ccr_card_model
    import ccr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic cardGo,
    input wire ccr_card_op_t cardOp,
    input wire logic cardRxReady,
    input wire logic okCfg,
    input wire logic [3:0] nData,
    output logic cardDone,
    output logic cardOk,
    output logic cardRxValid,
    output logic [7:0] cardRxData,
    output logic cardRxLast
);
    // Answer each start, then stream card data held until taken
    initial
    begin
        logic r;
        cardDone = 1'h0;
        cardOk = 1'h0;
        cardRxValid = 1'h0;
        cardRxData = 8'h00;
        cardRxLast = 1'h0;
        forever
        begin
            @(negedge ref_clk);
            if (cardGo === 1'h1)
            begin
                repeat (3) @(posedge ref_clk);
                #1 cardDone = 1'h1;
                cardOk = okCfg;
                @(posedge ref_clk);
                #1 cardDone = 1'h0;
                if (okCfg && cardOp inside {CARD_ACTIVATE, CARD_IDENTIFY, CARD_APDU, CARD_RAW, CARD_READ})
                    for (int i = 0; i < nData; i++)
                    begin
                        cardRxValid = 1'h1;
                        cardRxData = 8'ha0 + 8'(i);
                        cardRxLast = (i == nData - 1);
                        r = 1'h0;
                        while (!r)
                        begin
                            @(negedge ref_clk);
                            r = cardRxReady;
                            @(posedge ref_clk);
                        end
                        #1;
                    end
                cardRxValid = 1'h0;
                cardRxData = ~cardRxData; // Released bus shows no stale byte
                cardRxLast = 1'h0;
            end
        end
    end
endmodule

// [dv/tb_ccr_command_handler.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
// ============================================================
// Bench of the card command handler
module tb_ccr_command_handler import ccr_pkg::*;;
    logic ref_clk, txValid, antennaOn, autoMode, cardGo, cardCrcOn, cardFlush, cardTxValid, cardDone, cardOk;
    logic resetn = 1'h0, rxValid = 1'h0, rxBad = 1'h0, txReady = 1'h1, cardSense = 1'h0, stripeSwipe = 1'h0;
    logic cardHwReady = 1'h1, nvAutoMode = 1'h1, okCfg = 1'h0, cardRxValid, cardRxLast, cardRxReady;
    logic nvKeyWr, nvModeWr, nvModeAuto;
    logic [7:0] rxData = 8'h00, txData, cardTxData, cardRxData;
    logic [13:0] cardWaitMs;
    logic [2:0] nvKeySlot;
    logic [47:0] nvKeyData;
    logic [3:0] nData = 4'h2;
    ccr_card_op_t cardOp;
    logic [7:0] rxq[$];
    int n_errors = 0;
    int compares = 0;

    ccr_command_handler #(.GAP_CYCLES(20)) dut (.*);
    ccr_card_model card (.*);

    // Clock and host-side byte capture
    initial
    begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
        if (txValid === 1'h1 && txReady)
            rxq.push_back(txData);

    // ============================================================
    // Host tasks
    task automatic send(input string s, input int extra = 0, input logic bad = 1'h0); // Unframed bytes
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < s.len() + extra; i++)
        begin
            #1 rxValid = 1'h1;
            rxData = i < s.len() ? s[i] : 8'(i);
            rxBad = bad;
            @(posedge ref_clk);
        end
        #1 rxValid = 1'h0;
        rxBad = 1'h0;
    endtask
    task automatic expb(input string n, input logic [7:0] e);
        int k;
        logic [7:0] v;
        k = 0;
        while (rxq.size() == 0 && k < 400)
        begin
            @(posedge ref_clk);
            k++;
        end
        v = (rxq.size() == 0) ? 8'hxx : rxq.pop_front();
        `CHK(n, e, v)
        #1;
    endtask
    task automatic sense;
        repeat (40) @(posedge ref_clk);
        #1 cardSense = 1'h1;
        repeat (4) @(posedge ref_clk);
        #1 cardSense = 1'h0;
    endtask
    task automatic rst(input logic nv);
        nvAutoMode = nv;
        resetn = 1'h0;
        repeat (4) @(posedge ref_clk);
        #1 resetn = 1'h1;
        expb("power", RSP_POWER);
        `CHK("autoMode", nv, autoMode)
    endtask

    // ============================================================
    // Scenarios
    task automatic t_auto;
        send("O");
        expb("ant auto", RSP_FAIL);
        okCfg = 1'h1;
        nData = 4'h3;
        txReady = 1'h0;
        sense();
        repeat (30) @(posedge ref_clk);
        #1 txReady = 1'h1;
        for (int i = 0; i < 3; i++)
            expb("auto data", 8'ha0 + 8'(i));
        okCfg = 1'h0;
        sense();
        repeat (60) @(posedge ref_clk);
        `CHK("auto fail", 0, rxq.size())
    endtask
    task automatic t_host;
        send("H0");
        expb("auto off", RSP_ACK);
        `CHK("autoMode", 1'h0, autoMode)
        send("P");
        sense();
        expb("armed", RSP_ACK);
        send("H1");
        expb("auto on", RSP_ACK);
        `CHK("autoMode", 1'h1, autoMode)
        send("H0");
        expb("auto off", RSP_ACK);
    endtask
    task automatic t_err;
        send("{");
        expb("unknown", RSP_BAD);
        send("O", 0, 1'h1);
        expb("rx error", RSP_COMM);
        cardHwReady = 1'h0;
        send("y");
        expb("no hw", RSP_UNAVAIL);
        cardHwReady = 1'h1;
        send("J");
        expb("no ant", RSP_FAIL);
    endtask
    task automatic t_card;
        send("O");
        expb("ant on", RSP_ACK);
        okCfg = 1'h1;
        nData = 4'h2;
        send("J");
        expb("ats", 8'ha0);
        expb("ats", 8'ha1);
        nData = 4'h1;
        send("F");
        expb("card type", 8'ha0);
        nData = 4'h2;
        send("Z", 4);
        expb("apdu short", RSP_BAD);
        send("Z", 5);
        expb("apdu", 8'ha0);
        expb("apdu", 8'ha1);
        send("z29999", 2);
        expb("crc char", RSP_BAD);
        send("z09999", 2);
        expb("raw", 8'ha0);
        expb("raw", 8'ha1);
        `CHK("crc on", 1'h1, cardCrcOn)
        `CHK("wait", 14'h270f, cardWaitMs)
        send("z10012", 2);
        expb("raw", 8'ha0);
        expb("raw", 8'ha1);
        `CHK("crc off", 1'h0, cardCrcOn)
        `CHK("wait", 14'h000c, cardWaitMs)
        send("v032", 64);
        expb("sector short", RSP_BAD);
        send("v032", 256);
        expb("sector", RSP_ACK);
        send("y");
        expb("deselect", RSP_ACK);
        okCfg = 1'h0;
        send("y");
        expb("deselect", RSP_FAIL);
    endtask
    task automatic t_nv;
        send("j20123456789AB");
        expb("key", RSP_ACK);
        `CHK("slot", 3'h2, nvKeySlot)
        `CHK("key", 48'h0123456789ab, nvKeyData)
        send("j50123456789AB");
        expb("key slot", RSP_BAD);
        send("SA0");
        expb("persist", RSP_ACK);
        `CHK("mode", 1'h0, nvModeAuto)
        rst(1'h0);
    endtask

    // ============================================================
    // Run control
    task automatic results;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        rst(1'h1);
        t_auto();
        t_host();
        t_err();
        t_card();
        t_nv();
        results();
    end
    initial
    begin
        #100us;
        n_errors++;
        results();
    end
endmodule
